// *** common/segpin_map.vh ***
// constants for the lcd segment pin override mux
`ifndef SEGPIN_MAP_VH
`define SEGPIN_MAP_VH

// register offsets (byte addresses, one word each)
`define OFS_CTRL        8'h00
`define OFS_PORT1_OUT   8'h04
`define OFS_PORT1_DIR   8'h08
`define OFS_PORT2_OUT   8'h0c
`define OFS_PORT2_DIR   8'h10
`define OFS_PORT1_IN    8'h14
`define OFS_PORT2_IN    8'h18
`define OFS_PCMASK      8'h1c
`define OFS_STATUS      8'h20

// control register fields
`define CTRL_LCD_EN     0
`define CTRL_LCD_LP     1
`define CTRL_PCIE       2
`define CTRL_PUD        3
`define CTRL_W          4

// reset values
`define CTRL_RST        4'h0
`define PORT_RST        8'h00

// first pin-change source of each port
`define PC_BASE1        16
`define PC_BASE2        24

// front-plane segment number for each pin (port 1 bit 7..0, port 2 bit 6..0)
`define SEG_P1_7        6'd36
`define SEG_P1_6        6'd37
`define SEG_P1_5        6'd38
`define SEG_P1_4        6'd39
`define SEG_P1_3        6'd7
`define SEG_P1_2        6'd8
`define SEG_P1_1        6'd9
`define SEG_P1_0        6'd10
`define SEG_P2_6        6'd27
`define SEG_P2_5        6'd28
`define SEG_P2_4        6'd29
`define SEG_P2_3        6'd30
`define SEG_P2_2        6'd31
`define SEG_P2_1        6'd34
`define SEG_P2_0        6'd35

`endif

// *** logic/pin_override_cell.v ***
// one pin: override logic, input synchroniser and pad control
module pin_override_cell
(
	// clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// override controls
	input  wire lcd_enable_i,
	input  wire lcd_low_power_mode_i,
	input  wire pin_change_irq_enable_i,
	input  wire pc_mask_i,
	input  wire pullup_disable_i,
	// port registers
	input  wire port_out_i,
	input  wire port_dir_i,
	// lcd segment
	input  wire lcd_segment_drive_i,
	// pad
	input  wire pad_i,
	output wire pad_o,
	output wire pad_oe_n_o,
	output wire pad_pullup_o,
	output wire analog_path_o,
	// results
	output wire digital_input_tap_o,
	output wire input_enable_override_enable_o
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg din_reg;

	wire pullup_override_enable;
	wire direction_override_enable;
	wire port_value_override_enable;
	wire dir_eff;
	wire pu_eff;
	wire in_en;

	////////////////////////////////////////////////////////////////////////////
	assign pullup_override_enable    = lcd_enable_i;
	assign direction_override_enable = lcd_enable_i;
	assign port_value_override_enable = 1'b0;
	// override values are all zero: pull-up off, input
	assign dir_eff = direction_override_enable ? 1'b0 : port_dir_i;
	assign pu_eff  = pullup_override_enable ? 1'b0 :
		(~port_dir_i & port_out_i & ~pullup_disable_i);
	assign input_enable_override_enable_o = pc_mask_i & pin_change_irq_enable_i
		& lcd_enable_i & lcd_low_power_mode_i;
	// override value is one, so an enabled override keeps the buffer on
	assign in_en = 1'b1;

	assign pad_o        = port_value_override_enable ? 1'b0 : port_out_i;
	assign pad_oe_n_o   = ~dir_eff;
	assign pad_pullup_o = pu_eff;
	// segment waveform is passed through; pad is released while lcd owns it
	assign analog_path_o = lcd_enable_i & lcd_segment_drive_i;

	////////////////////////////////////////////////////////////////////////////
	// three stages; a change counts once stages two and three agree
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			din_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pad_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg && in_en)
				din_reg <= s3_reg;
		end
	end

	assign digital_input_tap_o = din_reg;
endmodule

// *** logic/lcd_segment_pin_override_mux.v ***
// lcd segment / pin-change override mux for two extra ports, wishbone slave
//
// Behaviour
// - port 1 bits 7..4 carry front-plane segments 36..39 and pin-change sources 23..20.
// - port 1 bits 3..0 carry front-plane segments 7..10 and pin-change sources 19..16.
// - port 2 bits 6..0 carry segments 27,28,29,30,31,34,35 and pin-change sources 30..24.
// - with lcd enabled each pin has pull-up forced off, direction forced input, value never forced.
// - input-enable override is mask bit and irq enable and lcd enable and low-power mode together.
// - each pin's digital input goes to the pin-change logic as its assigned source.
// - each pin's analog path carries the lcd drive of its assigned front-plane segment while lcd is enabled, and is low otherwise.
// - the pin cells of both ports exist only in the larger package variant; the port registers and bus exist in both.
`include "segpin_map.vh"
module lcd_segment_pin_override_mux
#(
	parameter LARGE_PACKAGE = 1
)
(
	// system
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// lcd segment drivers, indexed by segment number
	input  wire [39:0] lcd_segment_drive_i,
	// pads, port 1 (8 bits) and port 2 (7 bits)
	input  wire [7:0]  port1_pad_i,
	output wire [7:0]  port1_pad_o,
	output wire [7:0]  port1_pad_oe_n_o,
	output wire [7:0]  port1_pullup_o,
	output wire [7:0]  port1_analog_path_o,
	input  wire [6:0]  port2_pad_i,
	output wire [6:0]  port2_pad_o,
	output wire [6:0]  port2_pad_oe_n_o,
	output wire [6:0]  port2_pullup_o,
	output wire [6:0]  port2_analog_path_o,
	// to pin-change logic: sources 30..16 at bits 14..0
	output wire [14:0] pin_change_source_o,
	output wire [14:0] input_enable_override_o
);
	reg  [`CTRL_W-1:0] ctrl_reg;
	reg  [7:0]         p1_out_reg;
	reg  [7:0]         p1_dir_reg;
	reg  [6:0]         p2_out_reg;
	reg  [6:0]         p2_dir_reg;
	reg  [14:0]        pcmask_reg;
	reg  [31:0]        rd_next;

	wire        req;
	wire [14:0] pad_in;
	wire [14:0] pad_out;
	wire [14:0] pad_oe_n;
	wire [14:0] pad_pu;
	wire [14:0] pad_ana;
	wire [14:0] tap;
	wire [14:0] ieo;
	wire [14:0] out_all;
	wire [14:0] dir_all;
	wire [14:0] seg_drv;
	wire [89:0] seg_tab;

	////////////////////////////////////////////////////////////////////////////
	// segment table, pin index 14..0 = port 2 bit 6..0, port 1 bit 7..0
	assign seg_tab = {`SEG_P2_6, `SEG_P2_5, `SEG_P2_4, `SEG_P2_3, `SEG_P2_2,
		`SEG_P2_1, `SEG_P2_0, `SEG_P1_7, `SEG_P1_6, `SEG_P1_5, `SEG_P1_4,
		`SEG_P1_3, `SEG_P1_2, `SEG_P1_1, `SEG_P1_0};

	assign pad_in  = {port2_pad_i, port1_pad_i};
	assign out_all = {p2_out_reg, p1_out_reg};
	assign dir_all = {p2_dir_reg, p1_dir_reg};

	////////////////////////////////////////////////////////////////////////////
	// small variant: no cells at all, pads released and idle
	genvar g;
	generate
		if (LARGE_PACKAGE != 0)
		begin : g_ports
			for (g = 0; g < 15; g = g + 1)
			begin : g_pin
				assign seg_drv[g] = lcd_segment_drive_i[seg_tab[g*6 +: 6]];
				pin_override_cell u_cell
				(
					.clk_i                          (clk_i),
					.rst_i                          (rst_i),
					.lcd_enable_i                   (ctrl_reg[`CTRL_LCD_EN]),
					.lcd_low_power_mode_i           (ctrl_reg[`CTRL_LCD_LP]),
					.pin_change_irq_enable_i        (ctrl_reg[`CTRL_PCIE]),
					.pc_mask_i                      (pcmask_reg[g]),
					.pullup_disable_i               (ctrl_reg[`CTRL_PUD]),
					.port_out_i                     (out_all[g]),
					.port_dir_i                     (dir_all[g]),
					.lcd_segment_drive_i            (seg_drv[g]),
					.pad_i                          (pad_in[g]),
					.pad_o                          (pad_out[g]),
					.pad_oe_n_o                     (pad_oe_n[g]),
					.pad_pullup_o                   (pad_pu[g]),
					.analog_path_o                  (pad_ana[g]),
					.digital_input_tap_o            (tap[g]),
					.input_enable_override_enable_o (ieo[g])
				);
			end
		end
		else
		begin : g_none
			assign seg_drv  = 15'h0000;
			assign pad_out  = 15'h0000;
			assign pad_oe_n = 15'h7fff;
			assign pad_pu   = 15'h0000;
			assign pad_ana  = 15'h0000;
			assign tap      = 15'h0000;
			assign ieo      = 15'h0000;
		end
	endgenerate

	assign port1_pad_o         = pad_out[7:0];
	assign port2_pad_o         = pad_out[14:8];
	assign port1_pad_oe_n_o    = pad_oe_n[7:0];
	assign port2_pad_oe_n_o    = pad_oe_n[14:8];
	assign port1_pullup_o      = pad_pu[7:0];
	assign port2_pullup_o      = pad_pu[14:8];
	assign port1_analog_path_o = pad_ana[7:0];
	assign port2_analog_path_o = pad_ana[14:8];
	// bit k is source 16+k: port 1 gives 23..16, port 2 gives 30..24
	assign pin_change_source_o     = tap;
	assign input_enable_override_o = ieo;

	////////////////////////////////////////////////////////////////////////////
	// wishbone: ack one cycle after the strobe, dropped the next cycle
	assign req = cyc_i & stb_i & ~ack_o;

	always @*
	begin
		rd_next = 32'h00000000;
		case (adr_i)
			`OFS_CTRL:      rd_next = {28'h0000000, ctrl_reg};
			`OFS_PORT1_OUT: rd_next = {24'h000000, p1_out_reg};
			`OFS_PORT1_DIR: rd_next = {24'h000000, p1_dir_reg};
			`OFS_PORT2_OUT: rd_next = {25'h0, p2_out_reg};
			`OFS_PORT2_DIR: rd_next = {25'h0, p2_dir_reg};
			`OFS_PORT1_IN:  rd_next = {24'h000000, tap[7:0]};
			`OFS_PORT2_IN:  rd_next = {25'h0, tap[14:8]};
			`OFS_PCMASK:    rd_next = {17'h0, pcmask_reg};
			`OFS_STATUS:    rd_next = {17'h0, ieo};
			default:        rd_next = 32'h00000000;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o      <= 1'b0;
			dat_o      <= 32'h00000000;
			ctrl_reg   <= `CTRL_RST;
			p1_out_reg <= `PORT_RST;
			p1_dir_reg <= `PORT_RST;
			p2_out_reg <= 7'h00;
			p2_dir_reg <= 7'h00;
			pcmask_reg <= 15'h0000;
		end
		else
		begin
			ack_o <= req;
			if (req && !we_i)
				dat_o <= rd_next;
			if (req && we_i)
			begin
				case (adr_i)
					`OFS_CTRL:
						if (sel_i[0])
							ctrl_reg <= dat_i[`CTRL_W-1:0];
					`OFS_PORT1_OUT:
						if (sel_i[0])
							p1_out_reg <= dat_i[7:0];
					`OFS_PORT1_DIR:
						if (sel_i[0])
							p1_dir_reg <= dat_i[7:0];
					`OFS_PORT2_OUT:
						if (sel_i[0])
							p2_out_reg <= dat_i[6:0];
					`OFS_PORT2_DIR:
						if (sel_i[0])
							p2_dir_reg <= dat_i[6:0];
					`OFS_PCMASK:
					begin
						if (sel_i[0])
							pcmask_reg[7:0] <= dat_i[7:0];
						if (sel_i[1])
							pcmask_reg[14:8] <= dat_i[14:8];
					end
					default:
						ctrl_reg <= ctrl_reg;
				endcase
			end
		end
	end
endmodule

// *** verification/seg_pad_model.sv ***
// far side of the extra ports: segment electrodes and external level sources
module seg_pad_model
(
	// clock
	input  wire         clk_i,
	// from the pin mux
	input  wire  [14:0] pad_o,
	input  wire  [14:0] oe_n,
	input  wire  [14:0] pull,
	// external sources, one enable per pin
	input  wire  [14:0] src,
	input  wire  [14:0] src_en,
	// level seen on the pins
	output logic [14:0] pad_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] last_q;
	always_ff @(posedge clk_i)
		last_q <= pad_i;
	// a pin nobody drives and nothing pulls wanders instead of keeping its old level
	always_comb
		for (int i = 0; i < 15; i++)
			pad_i[i] = !oe_n[i] ? pad_o[i] : src_en[i] ? src[i] : pull[i] ? 1'b1 : ~last_q[i];
endmodule

// *** verification/lcd_segment_pin_override_mux_chk.sv ***
// assertions on the pins and bus of the lcd segment pin override mux
module lcd_segment_pin_override_mux_chk
(
	// bus
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        ack_o,
	// pins
	input wire [39:0] lcd_segment_drive_i,
	input wire [7:0]  port1_pad_oe_n_o,
	input wire [7:0]  port1_pullup_o,
	input wire [7:0]  port1_analog_path_o,
	input wire [6:0]  port2_pad_oe_n_o,
	input wire [6:0]  port2_pullup_o,
	input wire [6:0]  port2_analog_path_o,
	input wire [14:0] input_enable_override_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [39:0] d = lcd_segment_drive_i;
	wire [14:0] oe = {port2_pad_oe_n_o, port1_pad_oe_n_o};
	wire [14:0] pu = {port2_pullup_o, port1_pullup_o};
	wire [14:0] an = {port2_analog_path_o, port1_analog_path_o};
	wire [14:0] sg = {d[27], d[28], d[29], d[30], d[31], d[34], d[35],
		d[36], d[37], d[38], d[39], d[7], d[8], d[9], d[10]};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	p1_seg_a: assert property ((an[7:0] & ~sg[7:0]) == 8'h00)
		else $error("port 1 analog path off its segment");
	p2_seg_a: assert property ((an[14:8] & ~sg[14:8]) == 7'h00)
		else $error("port 2 analog path off its segment");
	lcd_force_a: assert property (|an |-> &oe && pu == 15'h0000)
		else $error("pin not forced to input without pull-up");
	ieo_lcd_a: assert property (|input_enable_override_o |-> an == sg && &oe)
		else $error("input override without lcd enabled");
	pull_dir_a: assert property ((pu & ~oe) == 15'h0000)
		else $error("pull-up on a driven pin");
	rst_idle_a: assert property ($fell(rst_i) |-> &oe && !ack_o && an == 15'h0000)
		else $error("pins not idle after reset");
	cover property (cyc_i && stb_i && ack_o);
	cover property (|input_enable_override_o);
	cover property (|an);
endmodule

bind lcd_segment_pin_override_mux lcd_segment_pin_override_mux_chk u_chk (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.lcd_segment_drive_i(lcd_segment_drive_i), .port1_pad_oe_n_o(port1_pad_oe_n_o),
	.port1_pullup_o(port1_pullup_o), .port1_analog_path_o(port1_analog_path_o),
	.port2_pad_oe_n_o(port2_pad_oe_n_o), .port2_pullup_o(port2_pullup_o),
	.port2_analog_path_o(port2_analog_path_o), .input_enable_override_o(input_enable_override_o));

// *** verification/lcd_segment_pin_override_mux_tb.sv ***
// self-checking bench for the lcd segment pin override mux
module lcd_segment_pin_override_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i, q;
	wire  [31:0] dat_o;
	wire         ack_o;
	logic [39:0] d;
	logic [14:0] s, se, m, o, r, dr, pin;
	wire  [14:0] pi, po, pe, pu, pa, pcs, ieo;
	wire  [14:0] po_s, pe_s, pu_s, pa_s, pcs_s, ieo_s;
	logic [3:0]  c;
	integer      seed, num_errors, n_checks, k;
	////////////////////////////////////////////////////////////////
	lcd_segment_pin_override_mux DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .lcd_segment_drive_i(d), .port1_pad_i(pi[7:0]),
		.port1_pad_o(po[7:0]), .port1_pad_oe_n_o(pe[7:0]), .port1_pullup_o(pu[7:0]),
		.port1_analog_path_o(pa[7:0]), .port2_pad_i(pi[14:8]), .port2_pad_o(po[14:8]),
		.port2_pad_oe_n_o(pe[14:8]), .port2_pullup_o(pu[14:8]),
		.port2_analog_path_o(pa[14:8]), .pin_change_source_o(pcs),
		.input_enable_override_o(ieo));
	seg_pad_model far (.clk_i(clk_i), .pad_o(po), .oe_n(pe), .pull(pu), .src(s),
		.src_en(se), .pad_i(pi));
	// small package variant sees the same bus writes but must keep its pins idle
	lcd_segment_pin_override_mux #(.LARGE_PACKAGE(0)) DUT_small (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
		.dat_i(dat_i), .dat_o(), .ack_o(), .lcd_segment_drive_i(d),
		.port1_pad_i(pi[7:0]), .port1_pad_o(po_s[7:0]), .port1_pad_oe_n_o(pe_s[7:0]),
		.port1_pullup_o(pu_s[7:0]), .port1_analog_path_o(pa_s[7:0]),
		.port2_pad_i(pi[14:8]), .port2_pad_o(po_s[14:8]), .port2_pad_oe_n_o(pe_s[14:8]),
		.port2_pullup_o(pu_s[14:8]), .port2_analog_path_o(pa_s[14:8]),
		.pin_change_source_o(pcs_s), .input_enable_override_o(ieo_s));
	////////////////////////////////////////////////////////////////
	function automatic [14:0] segmap(input [39:0] v);
		segmap = {v[27], v[28], v[29], v[30], v[31], v[34], v[35],
			v[36], v[37], v[38], v[39], v[7], v[8], v[9], v[10]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// entered just after a rising edge; the answer is waited for, never assumed
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int i;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= v;
		for (i = 0; i < 20 && ack_o !== 1'b1; i++)
			@(posedge clk_i);
		if (i == 20)
		begin
			num_errors++;
			finish_test;
		end
		else
		begin
			q = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		seed = 32'h737f1265;
		num_errors = 0;
		n_checks = 0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		d = 40'h0;
		s = 15'h0;
		se = 15'h7fff;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("oe_n reset", 15'h7fff, pe);
		wb(1'b1, 8'h24, 32'hffffffff);
		wb(1'b0, 8'h24, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("test reset done");
		// first passes are corners: all overrides on, then plain pulled-up inputs
		for (k = 0; k < 40; k++)
		begin
			c = (k == 0) ? 4'h7 : (k == 1) ? 4'h0 : 4'($random(seed));
			m = (k == 0) ? 15'h7fff : 15'($random(seed));
			r = (k == 1) ? 15'h0 : 15'($random(seed));
			o = (k == 1) ? 15'h7fff : 15'($random(seed));
			d <= 40'({$random(seed), $random(seed)});
			s <= 15'($random(seed));
			se <= (k == 1) ? 15'h0 : 15'h7fff;
			wb(1'b1, 8'h00, c);
			wb(1'b1, 8'h1c, m);
			wb(1'b1, 8'h04, o[7:0]);
			wb(1'b1, 8'h08, r[7:0]);
			wb(1'b1, 8'h0c, o[14:8]);
			wb(1'b1, 8'h10, r[14:8]);
			dr = r & {15{~c[0]}};
			pin = (dr & o) | (~dr & (s | ~se));
			wb(1'b0, 8'h20, 32'h0);
			chk("status", m & {15{&c[2:0]}}, q);
			chk("ieo", m & {15{&c[2:0]}}, ieo);
			wb(1'b0, 8'h00, 32'h0);
			chk("ctrl", c, q);
			wb(1'b0, 8'h14, 32'h0);
			chk("in1", pin[7:0], q);
			wb(1'b0, 8'h18, 32'h0);
			chk("in2", pin[14:8], q);
			chk("source", pin, pcs);
			chk("oe_n", c[0] ? 15'h7fff : 15'(~r), pe);
			chk("pullup", ~r & o & {15{~c[0] & ~c[3]}}, pu);
			chk("pad out", o, po);
			chk("analog", c[0] ? segmap(d) : 15'h0, pa);
			chk("small oe_n", 15'h7fff, pe_s);
			chk("small pins", 15'h0, po_s | pu_s | pa_s | pcs_s | ieo_s);
		end
		$display("test random done");
		// reset again in mid-run: registers and pins must return to idle
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("oe_n rerun", 15'h7fff, pe);
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl rerun", 32'h0, q);
		$display("test second reset done");
		finish_test;
	end
endmodule
